//--- pkg/adc_ctrl_pkg.sv
// Constants, types and register map shared by the converter control logic
package adc_ctrl_pkg;
   localparam int CLK_PERIOD_PS  = 8000;
   localparam int SETUP_TIME_NS  = 14000;
   localparam int SETUP_CYCLES   = (SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CONV_UNIT_NS   = 2000;
   localparam int CONV_UNIT_CYC  = (CONV_UNIT_NS * 1000) / CLK_PERIOD_PS;
   localparam int RESULT_W       = 10;

   localparam logic [7:0] OFS_MODE   = 8'h00;
   localparam logic [7:0] OFS_CHAN   = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_MASK   = 8'h10;
   localparam logic [7:0] OFS_THRESH = 8'h14;
   localparam logic [7:0] OFS_STATE  = 8'h18;

   localparam int MODE_RUN_BIT   = 7;
   localparam int MODE_TSEL_HI   = 5;
   localparam int MODE_TSEL_LO   = 3;
   localparam int MODE_PF_BIT    = 1;
   localparam int MODE_PWR_BIT   = 0;
   localparam int CHAN_W         = 3;
   localparam int ST_DONE_BIT    = 0;
   localparam int ST_PFAIL_BIT   = 1;
   localparam int IRQ_W          = 2;

   localparam logic [7:0]          MODE_RESET   = 8'h00;
   localparam logic [CHAN_W-1:0]   CHAN_RESET   = 3'h0;
   localparam logic [IRQ_W-1:0]    MASK_RESET   = 2'h0;
   localparam logic [7:0]          THRESH_RESET = 8'h00;

   typedef enum logic [1:0] {
      CONV_IDLE    = 2'b00,
      CONV_SAMPLE  = 2'b01,
      CONV_COMPARE = 2'b10
   } conv_state_e;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
   } reg_access_s;
endpackage

//--- hdl/sync2.sv
// Two-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/100ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

//--- hdl/ahb_reg_port.sv
// AHB-Lite slave front end: turns transfers into read and write strobes
`timescale 1ns/100ps
module ahb_reg_port (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               haddr,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output adc_ctrl_pkg::reg_access_s      acc
);
   logic       take;
   logic       wr_pend_q;
   logic [7:0] wr_addr_q;

   // Only whole-word transfers are decoded; others complete but do nothing
   assign take = hsel && hready && htrans[1] && (hsize == 3'h2);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= take && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // Read acts at the address phase, write in the data phase when hwdata stands
   assign acc.rd   = take && !hwrite;
   assign acc.wr   = wr_pend_q;
   assign acc.addr = acc.rd ? haddr[7:0] : wr_addr_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
endmodule

//--- hdl/adc_control_sequencer.sv
// Control sequencer of a successive-approximation converter with AHB-Lite registers
//
// Notes on behaviour
// - A conversion, sampling plus compare phase, lasts the time picked by mode bits 5..3; comparator settling comes first.
// - Standby stops all conversion activity.
// - A result read colliding with end of conversion returns the old value; new value lands next.
// - A mode or channel write colliding with end of conversion wins; result and interrupt dropped.
// - Rewriting the channel register leaves the conversion-done flag untouched.
`timescale 1ns/100ps
module adc_control_sequencer #(
   parameter int SETUP_CYC = adc_ctrl_pkg::SETUP_CYCLES,
   parameter int UNIT_CYC  = adc_ctrl_pkg::CONV_UNIT_CYC
) (
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   input  wire logic                              hsel,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       haddr,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic                                   hreadyout,
   output logic                                   hresp,
   output logic [31:0]                            hrdata,
   input  wire logic                              standby,
   input  wire logic                              comparator_out,
   output logic [adc_ctrl_pkg::RESULT_W-1:0]      dac_code,
   output logic [adc_ctrl_pkg::CHAN_W-1:0]        analog_input_select,
   output logic                                   sample_hold,
   output logic                                   comparator_enable,
   output logic                                   conversion_busy,
   output logic                                   conversion_done_interrupt
);
   localparam int RW = adc_ctrl_pkg::RESULT_W;

   initial begin
      // A bit step needs four cycles to see its trial code back through the synchroniser
      if (SETUP_CYC < 1 || UNIT_CYC < 48 || SETUP_CYC > 65535 || UNIT_CYC > 4096) begin
         $error("adc_control_sequencer: timing parameters out of range");
      end
   end

   // Conversion time in cycles for a time-select code: (code + 1) units
   function automatic logic [15:0] conv_cycles(input logic [2:0] code);
      conv_cycles = 16'((32'(code) + 32'd1) * 32'(UNIT_CYC));
   endfunction

   // Sampling takes about a sixth of the conversion; the bits share the rest
   function automatic logic [15:0] sample_cycles(input logic [2:0] code);
      sample_cycles = conv_cycles(code) / 16'd6;
   endfunction

   function automatic logic [15:0] bit_cycles(input logic [2:0] code);
      bit_cycles = (conv_cycles(code) - sample_cycles(code)) / 16'(RW);
   endfunction

   adc_ctrl_pkg::reg_access_s acc;
   logic                      standby_s;
   logic                      comp_s;

   ahb_reg_port u_port (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .haddr     (haddr),
      .hready    (hready),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .acc       (acc)
   );

   sync2 #(.W(2)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({standby, comparator_out}),
      .q       ({standby_s, comp_s})
   );

   logic [7:0]                       mode_q;
   logic [adc_ctrl_pkg::CHAN_W-1:0]  chan_q;
   logic [RW-1:0]                    result_q;
   logic [adc_ctrl_pkg::IRQ_W-1:0]   status_q;
   logic [adc_ctrl_pkg::IRQ_W-1:0]   mask_q;
   logic [adc_ctrl_pkg::IRQ_W-1:0]   st_clr;
   logic [7:0]                       thresh_q;
   adc_ctrl_pkg::conv_state_e        state_q;
   logic [15:0]                      tmr_q;
   logic [15:0]                      settle_q;
   logic                             settled_q;
   logic [RW-1:0]                    sar_q;
   logic [3:0]                       bitno_q;
   logic                             pend_q;
   logic [RW-1:0]                    pend_val_q;

   logic          run_en;
   logic          pwr_en;
   logic [2:0]    tsel;
   logic          wr_mode;
   logic          wr_chan;
   logic          rd_result;
   logic          eoc;
   logic [RW-1:0] sar_final;
   logic          done_set;
   logic          pf_set;
   logic          store_now;
   logic [RW-1:0] store_val;

   assign run_en    = mode_q[adc_ctrl_pkg::MODE_RUN_BIT];
   assign pwr_en    = mode_q[adc_ctrl_pkg::MODE_PWR_BIT];
   assign tsel      = mode_q[adc_ctrl_pkg::MODE_TSEL_HI:adc_ctrl_pkg::MODE_TSEL_LO];
   assign wr_mode   = acc.wr && (acc.addr == adc_ctrl_pkg::OFS_MODE);
   assign wr_chan   = acc.wr && (acc.addr == adc_ctrl_pkg::OFS_CHAN);
   assign rd_result = acc.rd && (acc.addr == adc_ctrl_pkg::OFS_RESULT);

   // Last bit decision folded in combinationally so the result is ready at the final edge
   assign eoc       = (state_q == adc_ctrl_pkg::CONV_COMPARE) && (tmr_q == 16'h0000)
                      && (bitno_q == 4'h0) && run_en && pwr_en && !standby_s;
   assign sar_final = comp_s ? sar_q : (sar_q & ~(RW'(1)));

   // Register writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q   <= adc_ctrl_pkg::MODE_RESET;
         chan_q   <= adc_ctrl_pkg::CHAN_RESET;
         mask_q   <= adc_ctrl_pkg::MASK_RESET;
         thresh_q <= adc_ctrl_pkg::THRESH_RESET;
      end else if (acc.wr) begin
         unique case (acc.addr)
            adc_ctrl_pkg::OFS_MODE:   mode_q   <= hwdata[7:0] & 8'hBB;
            adc_ctrl_pkg::OFS_CHAN:   chan_q   <= hwdata[adc_ctrl_pkg::CHAN_W-1:0];
            adc_ctrl_pkg::OFS_MASK:   mask_q   <= hwdata[adc_ctrl_pkg::IRQ_W-1:0];
            adc_ctrl_pkg::OFS_THRESH: thresh_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Comparator settling after power-up; restarts whenever power is removed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         settle_q  <= 16'h0000;
         settled_q <= 1'b0;
      end else if (!pwr_en || standby_s) begin
         settle_q  <= 16'h0000;
         settled_q <= 1'b0;
      end else if (!settled_q) begin
         settle_q  <= settle_q + 16'h0001;
         settled_q <= (settle_q == 16'(SETUP_CYC - 1));
      end
   end

   // Conversion sequencer: sampling then one bit per step, repeating while run stays set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= adc_ctrl_pkg::CONV_IDLE;
         tmr_q   <= 16'h0000;
         sar_q   <= '0;
         bitno_q <= 4'h0;
      end else if (standby_s || !run_en || !pwr_en || wr_chan) begin
         state_q <= adc_ctrl_pkg::CONV_IDLE;
         tmr_q   <= 16'h0000;
         bitno_q <= 4'h0;
      end else begin
         unique case (state_q)
            adc_ctrl_pkg::CONV_IDLE: begin
               if (settled_q) begin
                  state_q <= adc_ctrl_pkg::CONV_SAMPLE;
                  tmr_q   <= sample_cycles(tsel) - 16'h0001;
               end
            end
            adc_ctrl_pkg::CONV_SAMPLE: begin
               if (tmr_q == 16'h0000) begin
                  state_q <= adc_ctrl_pkg::CONV_COMPARE;
                  tmr_q   <= bit_cycles(tsel) - 16'h0001;
                  sar_q   <= RW'(1) << (RW - 1);
                  bitno_q <= 4'(RW - 1);
               end else begin
                  tmr_q <= tmr_q - 16'h0001;
               end
            end
            adc_ctrl_pkg::CONV_COMPARE: begin
               if (tmr_q != 16'h0000) begin
                  tmr_q <= tmr_q - 16'h0001;
               end else if (bitno_q == 4'h0) begin
                  state_q <= adc_ctrl_pkg::CONV_SAMPLE;
                  tmr_q   <= sample_cycles(tsel) - 16'h0001;
               end else begin
                  tmr_q   <= bit_cycles(tsel) - 16'h0001;
                  bitno_q <= bitno_q - 4'h1;
                  sar_q   <= (comp_s ? sar_q : (sar_q & ~(RW'(1) << bitno_q)))
                             | (RW'(1) << (bitno_q - 4'h1));
               end
            end
            default: state_q <= adc_ctrl_pkg::CONV_IDLE;
         endcase
      end
   end

   // Result update arbitration against bus accesses
   always_comb begin
      store_now = 1'b0;
      store_val = sar_final;
      done_set  = 1'b0;
      if (eoc && !(wr_mode || wr_chan)) begin
         done_set = 1'b1;
         if (!rd_result) begin
            store_now = 1'b1;
         end
      end else if (pend_q) begin
         store_now = 1'b1;
         store_val = pend_val_q;
      end
   end

   assign st_clr = (acc.wr && acc.addr == adc_ctrl_pkg::OFS_STATUS)
                   ? hwdata[adc_ctrl_pkg::IRQ_W-1:0] : '0;

   assign pf_set = done_set && mode_q[adc_ctrl_pkg::MODE_PF_BIT]
                   && (sar_final[RW-1:RW-8] <= thresh_q);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_q   <= '0;
         pend_q     <= 1'b0;
         pend_val_q <= '0;
      end else begin
         if (store_now) begin
            result_q <= store_val;
         end
         // Read sees the old value; the new one lands on the following edge
         pend_q     <= done_set && rd_result;
         pend_val_q <= sar_final;
      end
   end

   // Sticky status, write one to clear; a set in the same cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= '0;
      end else begin
         // Channel writes do not touch the flags
         status_q <= (status_q & ~st_clr)
                     | {pf_set, done_set};
      end
   end

   // Read data is captured in the address phase and stands through the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc.rd) begin
         unique case (acc.addr)
            adc_ctrl_pkg::OFS_MODE:   hrdata <= {24'h00_0000, mode_q};
            adc_ctrl_pkg::OFS_CHAN:   hrdata <= {29'h000_0000, chan_q};
            adc_ctrl_pkg::OFS_RESULT: hrdata <= {22'h0_0000, result_q};
            adc_ctrl_pkg::OFS_STATUS: hrdata <= {30'h000_0000, status_q};
            adc_ctrl_pkg::OFS_MASK:   hrdata <= {30'h000_0000, mask_q};
            adc_ctrl_pkg::OFS_THRESH: hrdata <= {24'h00_0000, thresh_q};
            adc_ctrl_pkg::OFS_STATE:  hrdata <= {28'h000_0000, settled_q, 1'b0, state_q};
            default:                  hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Analog side drive; sample_hold, comparator_enable and conversion_busy drop in standby
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dac_code                  <= '0;
         analog_input_select       <= '0;
         sample_hold               <= 1'b0;
         comparator_enable         <= 1'b0;
         conversion_busy           <= 1'b0;
         conversion_done_interrupt <= 1'b0;
      end else begin
         dac_code            <= sar_q;
         analog_input_select <= chan_q;
         sample_hold         <= (state_q == adc_ctrl_pkg::CONV_SAMPLE) && !standby_s;
         comparator_enable   <= pwr_en && !standby_s;
         conversion_busy     <= (state_q != adc_ctrl_pkg::CONV_IDLE) && !standby_s;
         conversion_done_interrupt <= |(status_q & mask_q);
      end
   end
endmodule

//--- sim/adc_control_sequencer_asserts.sv
// Port-level checker for the converter control sequencer
`timescale 1ns/100ps
module adc_control_sequencer_asserts #(
   parameter int UNIT_CYC = 250
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] haddr,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic        standby,
   input wire logic [2:0]  analog_input_select,
   input wire logic        sample_hold,
   input wire logic        comparator_enable,
   input wire logic        conversion_busy
);
   logic        wr_q;
   logic        rd_q;
   logic [7:0]  addr_q;
   logic [2:0]  tsel_q;
   logic        clean_q;
   int unsigned cnt_q;
   logic        chan_wr;
   logic        cfg_wr;
   assign chan_wr = wr_q && addr_q == adc_ctrl_pkg::OFS_CHAN;
   assign cfg_wr  = chan_wr || (wr_q && addr_q == adc_ctrl_pkg::OFS_MODE);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         addr_q  <= 8'h00;
         tsel_q  <= 3'h0;
         clean_q <= 1'b0;
         cnt_q   <= 0;
      end else begin
         wr_q    <= hsel && hready && htrans[1] && hwrite;
         rd_q    <= hsel && hready && htrans[1] && !hwrite;
         addr_q  <= haddr[7:0];
         cnt_q   <= sample_hold ? cnt_q + 1 : 0;
         // A sample cut short by a rewrite or standby has no fixed length
         clean_q <= !sample_hold || (clean_q && !cfg_wr && !standby);
         if (wr_q && addr_q == adc_ctrl_pkg::OFS_MODE) begin
            tsel_q <= hwdata[5:3];
         end
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_ready_high: assert property (hreadyout) else $error("wait state seen");
   chk_resp_okay: assert property (!hresp) else $error("error response seen");
   chk_standby_halt: assert property (standby [*6] |-> !conversion_busy && !sample_hold)
      else $error("conversion runs in standby");
   chk_standby_power: assert property (standby [*6] |-> !comparator_enable)
      else $error("comparator powered in standby");
   chk_sample_len: assert property ($fell(sample_hold) && clean_q |->
      cnt_q == ((int'(tsel_q) + 1) * UNIT_CYC) / 6) else $error("sample length wrong");
   chk_sample_busy: assert property (sample_hold |-> conversion_busy)
      else $error("sampling while idle");
   chk_select_cause: assert property ($changed(analog_input_select) |->
      $past(chan_wr) || $past(chan_wr, 2)) else $error("channel moved unasked");
   chk_mode_pad: assert property (rd_q && addr_q == adc_ctrl_pkg::OFS_MODE |->
      hrdata[31:8] == 24'h00_0000 && !hrdata[6] && !hrdata[2]) else $error("mode pad set");
endmodule
bind adc_control_sequencer adc_control_sequencer_asserts #(.UNIT_CYC(UNIT_CYC)) chk_i (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .haddr, .hwdata, .hready, .hreadyout, .hresp,
   .hrdata, .standby, .analog_input_select, .sample_hold, .comparator_enable, .conversion_busy
);

//--- sim/analog_src.sv
// Behavioural analog sources behind the input multiplexer, with comparator
`timescale 1ns/100ps
module analog_src (
   input  wire logic            hclk,
   input  wire logic [7:0][9:0] level,
   input  wire logic [2:0]      analog_input_select,
   input  wire logic            sample_hold,
   input  wire logic            comparator_enable,
   input  wire logic [9:0]      dac_code,
   output logic                 comparator_out
);
   logic [9:0] held_q = 10'h000;
   logic       junk_q = 1'b0;
   always @(posedge hclk) begin
      junk_q <= ~junk_q;
      if (sample_hold) begin
         held_q <= level[analog_input_select];
      end
   end
   // An unpowered comparator gives a toggling, useless answer
   assign comparator_out = comparator_enable ? (held_q >= dac_code) : junk_q;
endmodule

//--- sim/adc_control_sequencer_test.sv
// Self-checking register-level test of the converter control sequencer
`timescale 1ns/100ps
module adc_control_sequencer_test;
   localparam int UNIT = 60;
   localparam int SETUP = 8;
   logic            hclk = 1'b0;
   logic            hresetn = 1'b0;
   logic [1:0]      htrans = 2'b00;
   logic            hwrite = 1'b0;
   logic [31:0]     haddr = 32'h0000_0000;
   logic [31:0]     hwdata = 32'h0000_0000;
   logic            hready;
   logic            hresp;
   logic [31:0]     hrdata;
   logic            standby = 1'b0;
   logic            cmp;
   logic [9:0]      dac;
   logic [2:0]      sel;
   logic            sh;
   logic            cen;
   logic            busy;
   logic            irq;
   logic [7:0][9:0] level = '0;
   logic [2:0]      ts [2] = '{3'h3, 3'h0};
   logic [31:0]     q;
   int              bad_count = 0;
   int              n_compared = 0;
   int              cyc = 0;
   int              t;
   int              p;
   int              c;
   always #4 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   adc_control_sequencer #(.SETUP_CYC(SETUP), .UNIT_CYC(UNIT)) adc_control_sequencer_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .haddr(haddr), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .standby(standby), .comparator_out(cmp),
      .dac_code(dac), .analog_input_select(sel), .sample_hold(sh),
      .comparator_enable(cen), .conversion_busy(busy), .conversion_done_interrupt(irq)
   );
   analog_src analog_src_i (.hclk(hclk), .level(level), .analog_input_select(sel),
      .sample_hold(sh), .comparator_enable(cen), .dac_code(dac), .comparator_out(cmp));
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h00_0000, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp);
   endtask
   task automatic wirq();
      while (irq !== 1'b1) @(posedge hclk);
      t = cyc;
   endtask
   // The request output lags the status bit by one cycle
   task automatic clr();
      bus(1'b1, adc_ctrl_pkg::OFS_STATUS, 32'h0000_0001);
      repeat (2) @(posedge hclk);
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int a = 0; a <= 8'h1c; a += 4) begin
         rdc(8'(a), 32'h0000_0000);
      end
      bus(1'b1, 8'h1c, 32'hffff_ffff);
      rdc(8'h1c, 32'h0000_0000);
      bus(1'b1, adc_ctrl_pkg::OFS_RESULT, 32'hffff_ffff);
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_0000);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'hffff_ffff);
      rdc(adc_ctrl_pkg::OFS_MODE, 32'h0000_00bb);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0000);
      $display("registers done");
      level[0] <= 10'h2a5;
      level[3] <= 10'h15a;
      bus(1'b1, adc_ctrl_pkg::OFS_MASK, 32'h0000_0001);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0001);
      repeat (SETUP + 4) @(posedge hclk);
      foreach (ts[k]) begin
         c = (int'(ts[k]) + 1) * UNIT;
         bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0001);
         bus(1'b1, adc_ctrl_pkg::OFS_MODE, {24'h00_0000, 2'b10, ts[k], 3'b001});
         wirq();
         rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0001);
         rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_02a5);
         clr();
         wirq();
         p = t;
         clr();
         wirq();
         p = t - p;
         chk(32'(p >= c && p <= c + 2), 32'h0000_0001);
      end
      $display("conversion time done");
      level[0] <= 10'h0f0;
      clr();
      while (cyc < t + p - 4) @(posedge hclk);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0081);
      rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
      // A flag kept at the conflict would have reached the request output by now
      chk({31'h0, irq}, 32'h0000_0000);
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_02a5);
      wirq();
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_00f0);
      level[0] <= 10'h30c;
      clr();
      while (cyc < t + p - 3) @(posedge hclk);
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_00f0);
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_030c);
      rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0001);
      $display("conflicts done");
      repeat (20) @(posedge hclk);
      bus(1'b1, adc_ctrl_pkg::OFS_CHAN, 32'h0000_0003);
      rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0001);
      clr();
      wirq();
      rdc(adc_ctrl_pkg::OFS_RESULT, 32'h0000_015a);
      clr();
      bus(1'b1, adc_ctrl_pkg::OFS_MASK, 32'h0000_0000);
      repeat (2 * p) @(posedge hclk);
      rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0000);
      bus(1'b1, adc_ctrl_pkg::OFS_MASK, 32'h0000_0001);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0000_0001);
      // Result 0x15a gives 0x56 in its upper eight bits, just at the threshold
      bus(1'b1, adc_ctrl_pkg::OFS_THRESH, 32'h0000_0056);
      rdc(adc_ctrl_pkg::OFS_THRESH, 32'h0000_0056);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0083);
      bus(1'b1, adc_ctrl_pkg::OFS_STATUS, 32'h0000_0003);
      repeat (2) @(posedge hclk);
      wirq();
      rdc(adc_ctrl_pkg::OFS_STATUS, 32'h0000_0003);
      $display("channel and mask done");
      standby <= 1'b1;
      repeat (8) @(posedge hclk);
      chk({31'h0, busy}, 32'h0000_0000);
      chk({31'h0, cen}, 32'h0000_0000);
      bus(1'b1, adc_ctrl_pkg::OFS_MODE, 32'h0000_0000);
      standby <= 1'b0;
      $display("standby done");
      stop_test();
   end
endmodule
